// ===== cri_defs.svh
`ifndef CRI_DEFS_SVH
`define CRI_DEFS_SVH
`define CRI_OP_RETI_MASK  16'hFFFE
`define CRI_OP_RETI_CODE  16'h0010
`define CRI_OP_RETS_MASK  16'hFFFE
`define CRI_OP_RETS_CODE  16'h0012
`define CRI_OP_RETL_MASK  16'hFF00
`define CRI_OP_RETL_CODE  16'h0C00
`define CRI_S_BIT         0
`define CRI_K_MSB         7
`define CRI_PC_RESET      21'h00_0000
`define CRI_BYTE_RESET    8'h00
`define CRI_BSR_RESET     4'h0
`define CRI_Q_LAST        2'h3
`define CRI_Q_FIRST       2'h0
`endif

// ===== cri_pkg.sv
package cri_pkg;
    typedef enum logic [2:0] {
        CRI_IDLE  = 3'b001,
        CRI_EXEC  = 3'b010,
        CRI_FLUSH = 3'b100
    } cri_state_t;
    typedef enum logic [1:0] {
        CRI_OP_NONE = 2'b00,
        CRI_OP_RETI = 2'b01,
        CRI_OP_RETS = 2'b10,
        CRI_OP_RETL = 2'b11
    } cri_op_t;
endpackage : cri_pkg

// ===== cri_decode.sv
`timescale 1ns/1ps
`include "cri_defs.svh"
module cri_decode (
    input  wire logic [15:0]      i_opcode,
    output cri_pkg::cri_op_t      o_op,
    output logic                  o_s,
    output logic [7:0]            o_literal
);
    always_comb begin
        o_s       = i_opcode[`CRI_S_BIT];
        o_literal = i_opcode[`CRI_K_MSB:0];
        if ((i_opcode & `CRI_OP_RETI_MASK) == `CRI_OP_RETI_CODE) begin
            o_op = cri_pkg::CRI_OP_RETI;
        end else if ((i_opcode & `CRI_OP_RETS_MASK) == `CRI_OP_RETS_CODE) begin
            o_op = cri_pkg::CRI_OP_RETS;
        end else if ((i_opcode & `CRI_OP_RETL_MASK) == `CRI_OP_RETL_CODE) begin
            o_op = cri_pkg::CRI_OP_RETL;
        end else begin
            o_op = cri_pkg::CRI_OP_NONE;
        end
    end
endmodule : cri_decode

// ===== cri_return_unit.sv
`timescale 1ns/1ps
`include "cri_defs.svh"
module cri_return_unit (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic [1:0]  i_q_phase,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_opcode,
    input  wire logic [20:0] i_stack_top,
    input  wire logic [7:0]  i_shadow_working_reg,
    input  wire logic [7:0]  i_shadow_flags_reg,
    input  wire logic [3:0]  i_shadow_bank_select,
    input  wire logic        i_priority_mode,
    input  wire logic        i_high_prio_active,
    output logic [20:0]      o_pc,
    output logic             o_pc_load,
    output logic             o_stack_pop,
    output logic [7:0]       o_working_reg,
    output logic [7:0]       o_flags_reg,
    output logic [3:0]       o_bank_select_reg,
    output logic             o_regs_load,
    output logic             o_high_prio_irq_enable_set,
    output logic             o_low_prio_irq_enable_set,
    output logic             o_busy
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    cri_pkg::cri_op_t   dec_op;
    logic               dec_s;
    logic [7:0]         dec_lit;
    cri_pkg::cri_state_t state_ff;
    cri_pkg::cri_op_t   op_ff;
    logic               s_ff;
    logic [7:0]         lit_ff;
    logic               q_last;
    logic               q_first;
    logic               accept;
    logic               fire;

    cri_decode u_decode (
        .i_opcode  (i_opcode),
        .o_op      (dec_op),
        .o_s       (dec_s),
        .o_literal (dec_lit)
    );

    assign q_last  = (i_q_phase == `CRI_Q_LAST);
    assign q_first = (i_q_phase == `CRI_Q_FIRST);
    assign accept  = (state_ff == cri_pkg::CRI_IDLE) && q_first && i_instr_valid
                     && (dec_op != cri_pkg::CRI_OP_NONE);
    assign fire    = (state_ff == cri_pkg::CRI_EXEC) && q_last;

    // ----------------------------------------
    // Sequencer: decode cycle then forced nop cycle
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= cri_pkg::CRI_IDLE;
        end else begin
            unique case (state_ff)
                cri_pkg::CRI_IDLE: begin
                    if (accept) begin
                        state_ff <= cri_pkg::CRI_EXEC;
                    end
                end
                cri_pkg::CRI_EXEC: begin
                    if (q_last) begin
                        state_ff <= cri_pkg::CRI_FLUSH;
                    end
                end
                cri_pkg::CRI_FLUSH: begin
                    if (q_last) begin
                        state_ff <= cri_pkg::CRI_IDLE;
                    end
                end
                default: begin
                    state_ff <= cri_pkg::CRI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            op_ff  <= cri_pkg::CRI_OP_NONE;
            s_ff   <= 1'b0;
            lit_ff <= `CRI_BYTE_RESET;
        end else if (accept) begin
            op_ff  <= dec_op;
            s_ff   <= dec_s;
            lit_ff <= dec_lit;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_ff != cri_pkg::CRI_IDLE) || accept;
        end
    end

    // ----------------------------------------
    // Program counter and stack pop at Q4
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pc        <= `CRI_PC_RESET;
            o_pc_load   <= 1'b0;
            o_stack_pop <= 1'b0;
        end else begin
            o_pc_load   <= fire;
            o_stack_pop <= fire;
            if (fire) begin
                o_pc <= i_stack_top;
            end
        end
    end

    // ----------------------------------------
    // Working, flags, bank select restore
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_working_reg     <= `CRI_BYTE_RESET;
            o_flags_reg       <= `CRI_BYTE_RESET;
            o_bank_select_reg <= `CRI_BSR_RESET;
            o_regs_load       <= 1'b0;
        end else begin
            o_regs_load <= 1'b0;
            if (fire && (op_ff == cri_pkg::CRI_OP_RETL)) begin
                o_working_reg <= lit_ff;
                o_regs_load   <= 1'b1;
            end else if (fire && s_ff) begin
                o_working_reg     <= i_shadow_working_reg;
                o_flags_reg       <= i_shadow_flags_reg;
                o_bank_select_reg <= i_shadow_bank_select;
                o_regs_load       <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Interrupt enable re-arm
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_high_prio_irq_enable_set <= 1'b0;
            o_low_prio_irq_enable_set  <= 1'b0;
        end else begin
            o_high_prio_irq_enable_set <= fire && (op_ff == cri_pkg::CRI_OP_RETI)
                && (!i_priority_mode || i_high_prio_active);
            o_low_prio_irq_enable_set  <= fire && (op_ff == cri_pkg::CRI_OP_RETI)
                && (!i_priority_mode || !i_high_prio_active);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_take;
        accept;
    endsequence

    // Q2 to Q4 of the first instruction cycle
    sequence s_exec_cycle;
        (state_ff == cri_pkg::CRI_EXEC)[*3];
    endsequence

    // Forced nop instruction cycle, Q1 to Q4
    sequence s_nop_cycle;
        (state_ff == cri_pkg::CRI_FLUSH)[*4];
    endsequence

    property p_pc_pop;
        @(posedge i_clock) disable iff (!i_reset_n)
        fire |=> o_pc_load && o_stack_pop && (o_pc == $past(i_stack_top));
    endproperty
    a_pc_pop: assert property (p_pc_pop) else $error("pc not loaded from stack top");

    property p_reti_arm;
        @(posedge i_clock) disable iff (!i_reset_n)
        (fire && op_ff == cri_pkg::CRI_OP_RETI)
            |=> (o_high_prio_irq_enable_set || o_low_prio_irq_enable_set);
    endproperty
    a_reti_arm: assert property (p_reti_arm) else $error("irq enable not set");

    property p_restore;
        @(posedge i_clock) disable iff (!i_reset_n)
        (fire && s_ff && op_ff != cri_pkg::CRI_OP_RETL)
            |=> o_regs_load && (o_working_reg == $past(i_shadow_working_reg))
                && (o_flags_reg == $past(i_shadow_flags_reg))
                && (o_bank_select_reg == $past(i_shadow_bank_select));
    endproperty
    a_restore: assert property (p_restore) else $error("shadow restore missing");

    property p_no_restore;
        @(posedge i_clock) disable iff (!i_reset_n)
        (fire && !s_ff && op_ff != cri_pkg::CRI_OP_RETL)
            |=> !o_regs_load && $stable(o_flags_reg) && $stable(o_working_reg);
    endproperty
    a_no_restore: assert property (p_no_restore) else $error("regs changed with s=0");

    property p_rets_decode;
        @(posedge i_clock) disable iff (!i_reset_n)
        (accept && i_opcode[15:1] == 15'h0009) |=> op_ff == cri_pkg::CRI_OP_RETS;
    endproperty
    a_rets_decode: assert property (p_rets_decode) else $error("return not decoded");

    property p_literal;
        @(posedge i_clock) disable iff (!i_reset_n)
        (fire && op_ff == cri_pkg::CRI_OP_RETL) |=> o_working_reg == $past(lit_ff);
    endproperty
    a_literal: assert property (p_literal) else $error("literal not written");

    property p_two_cycles;
        @(posedge i_clock) disable iff (!i_reset_n)
        s_take |=> s_exec_cycle ##1 s_nop_cycle
            ##1 (state_ff == cri_pkg::CRI_IDLE);
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("not two cycles");

    property p_pc_timing;
        @(posedge i_clock) disable iff (!i_reset_n)
        s_take |-> ##4 o_pc_load;
    endproperty
    a_pc_timing: assert property (p_pc_timing) else $error("pc load late");

endmodule : cri_return_unit

// ===== cri_return_unit_tb_top.sv
`timescale 1ns/1ps
module cri_return_unit_tb_top;
    logic        i_clock;
    logic        i_reset_n;
    logic [1:0]  i_q_phase;
    logic        i_instr_valid;
    logic [15:0] i_opcode;
    logic [20:0] i_stack_top;
    logic [7:0]  i_shadow_working_reg;
    logic [7:0]  i_shadow_flags_reg;
    logic [3:0]  i_shadow_bank_select;
    logic        i_priority_mode;
    logic        i_high_prio_active;
    logic [20:0] o_pc;
    logic        o_pc_load;
    logic        o_stack_pop;
    logic [7:0]  o_working_reg;
    logic [7:0]  o_flags_reg;
    logic [3:0]  o_bank_select_reg;
    logic        o_regs_load;
    logic        o_high_prio_irq_enable_set;
    logic        o_low_prio_irq_enable_set;
    logic        o_busy;
    int          n_errors;
    int          checked;
    int          cycles;
    logic [7:0]  exp_w;
    logic [7:0]  exp_f;
    logic [3:0]  exp_b;

    cri_return_unit i_dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_q_phase(i_q_phase),
        .i_instr_valid(i_instr_valid), .i_opcode(i_opcode), .i_stack_top(i_stack_top),
        .i_shadow_working_reg(i_shadow_working_reg), .i_shadow_flags_reg(i_shadow_flags_reg),
        .i_shadow_bank_select(i_shadow_bank_select), .i_priority_mode(i_priority_mode),
        .i_high_prio_active(i_high_prio_active), .o_pc(o_pc), .o_pc_load(o_pc_load),
        .o_stack_pop(o_stack_pop), .o_working_reg(o_working_reg), .o_flags_reg(o_flags_reg),
        .o_bank_select_reg(o_bank_select_reg), .o_regs_load(o_regs_load),
        .o_high_prio_irq_enable_set(o_high_prio_irq_enable_set),
        .o_low_prio_irq_enable_set(o_low_prio_irq_enable_set), .o_busy(o_busy)
    );

    initial i_clock = 1'b0;
    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            i_q_phase <= #1 2'h0;
        end else begin
            i_q_phase <= #1 i_q_phase + 2'h1;
        end
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            test_done();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic test_done();
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Drive one instruction at the next Q1 edge
    task automatic present(input logic [15:0] op);
        do @(posedge i_clock); while (i_q_phase !== 2'h3);
        #1;
        i_opcode      = op;
        i_instr_valid = 1'b1;
    endtask : present

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic run(input logic [15:0] op, input logic [20:0] stack_top, input logic pm,
                       input logic hp);
        logic ret_s;
        logic rl;
        ret_s = (op[15:1] == 15'h0008 || op[15:1] == 15'h0009);
        rl    = 1'b0;
        present(op);
        i_stack_top          = stack_top;
        i_shadow_working_reg = stack_top[7:0] ^ 8'ha5;
        i_shadow_flags_reg   = stack_top[15:8];
        i_shadow_bank_select = stack_top[20:17];
        i_priority_mode      = pm;
        i_high_prio_active   = hp;
        if (ret_s && op[0]) begin
            {exp_w, exp_f, exp_b} = {stack_top[7:0] ^ 8'ha5, stack_top[15:8], stack_top[20:17]};
            rl = 1'b1;
        end
        if (op[15:8] == 8'h0c) begin
            exp_w = op[7:0];
            rl    = 1'b1;
        end
        @(posedge i_clock);
        #1 i_opcode = 16'h0013;
        @(posedge i_clock);
        #1 chk(o_busy, 1'b1);
        repeat (2) @(posedge i_clock);
        #2 chk(o_pc_load, 1'b1);
        chk(o_stack_pop, 1'b1);
        chk(o_pc, stack_top);
        chk(o_regs_load, rl);
        chk(o_working_reg, exp_w);
        chk(o_flags_reg, exp_f);
        chk(o_bank_select_reg, exp_b);
        chk(o_high_prio_irq_enable_set, op[15:1] == 15'h0008 && (!pm || hp));
        chk(o_low_prio_irq_enable_set, op[15:1] == 15'h0008 && (!pm || !hp));
        @(posedge i_clock);
        #1 i_instr_valid = 1'b0;
        #1 chk(o_pc_load | o_stack_pop | o_regs_load, 1'b0);
    endtask : run

    task automatic refuse(input logic [15:0] op);
        present(op);
        @(posedge i_clock);
        #1 i_instr_valid = 1'b0;
        repeat (6) begin
            @(posedge i_clock);
            #2 chk(o_pc_load | o_busy, 1'b0);
        end
    endtask : refuse

    initial begin
        {i_reset_n, i_instr_valid, i_opcode, i_stack_top} = '0;
        {i_shadow_working_reg, i_shadow_flags_reg, i_shadow_bank_select} = '0;
        {i_priority_mode, i_high_prio_active, exp_w, exp_f, exp_b} = '0;
        repeat (16) @(posedge i_clock);
        #1 i_reset_n = 1'b1;
        chk(o_pc | o_busy | o_working_reg, 21'h0_0000);
        run(16'h0010, 21'h1_2345, 1'b0, 1'b0);
        run(16'h0011, 21'h0_0abc, 1'b1, 1'b1);
        run(16'h0010, 21'h1_fffe, 1'b1, 1'b0);
        run(16'h0012, 21'h0_4321, 1'b0, 1'b0);
        run(16'h0013, 21'h1a_5c3d, 1'b1, 1'b1);
        run(16'h0012, 21'h0_7777, 1'b0, 1'b0);
        run(16'h0c00, 21'h0_0002, 1'b0, 1'b0);
        run(16'h0cff, 21'h1_5a5a, 1'b1, 1'b1);
        refuse(16'h0014);
        refuse(16'h0006);
        refuse(16'h0d12);
        test_done();
    end
endmodule : cri_return_unit_tb_top
